// [core/nib_alu_pkg.sv]
// Package for the nibble add/subtract/skip execution unit.
// Assumes a core that fetches 16-bit words and owns a 64x4 data memory.
package nib_alu_pkg;
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam int ROW_W = 2;
  localparam int COL_W = 4;
  localparam int ADDR_W = ROW_W + COL_W;
  // Opcode field positions
  localparam int GRP_HI = 15;
  localparam int GRP_LO = 14;
  localparam int SUB_BIT = 13;
  localparam int IMM_BIT = 12;
  localparam int CIN_BIT = 11;
  localparam int SKIP_BIT = 10;
  localparam int ROW_HI = 9;
  localparam int ROW_LO = 8;
  localparam int COL_HI = 7;
  localparam int COL_LO = 4;
  localparam int OPD_HI = 3;
  localparam int OPD_LO = 0;
  localparam logic [1:0] GRP_ARITH = 2'h1;
  localparam logic [NIB_W-1:0] NIB_ZERO = 4'h0;
  localparam logic FLAG_RESET = 1'b0;

  // Decoded instruction fields
  typedef struct packed {
    logic arith;
    logic sub;
    logic imm;
    logic cin;
    logic skip;
    logic [ROW_W-1:0] row_field;
    logic [COL_W-1:0] column_field;
    logic [NIB_W-1:0] operand;
  } dec_t;

  // Write-back request toward register file or data memory
  typedef struct packed {
    logic reg_we;
    logic [NIB_W-1:0] work_reg_num;
    logic mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [NIB_W-1:0] data;
  } wb_t;
endpackage : nib_alu_pkg

// [core/nibble_add_sub_skip_unit.sv]
// Nibble add/subtract execution unit with carry/borrow flag and skip.
// Assumes the core presents the word, register and memory nibbles in the
// same cycle as instr_valid; write-back and skip are registered.
//
// Operation
// - Register plus memory goes to register, never skips.
// - Add skip variants skip next instruction on carry out.
// - Register plus memory plus carry flag goes to register.
// - Register plus memory plus carry to register, skip on carry.
// - Immediate plus memory written back to the same memory nibble.
// - Immediate plus memory plus carry written back to memory.
// - Register minus memory goes to register, never skips.
// - Register subtract skip variants skip on borrow.
// - Register minus memory minus borrow flag goes to register.
// - Memory minus immediate written back to memory.
// - Memory minus immediate to memory, skip on borrow.
// - Memory minus immediate minus borrow written to memory.
// - Bits 9..8 form the two-bit memory row address.
// - Bits 7..4 form column; register number or immediate four bits.
// - Opcode bits 15..10: group 01, sub, imm, carry-in, skip.
// - Operand fields sit at fixed bit positions in every word.
// - Memory minus immediate minus borrow to memory, skip on borrow.
`timescale 1ns/1ps
module nibble_add_sub_skip_unit #(
  parameter int NIB = 4
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire logic [nib_alu_pkg::WORD_W-1:0] instr,
  input wire logic [nib_alu_pkg::NIB_W-1:0] reg_data,
  input wire logic [nib_alu_pkg::NIB_W-1:0] mem_data,
  output logic [nib_alu_pkg::NIB_W-1:0] reg_sel,
  output logic [nib_alu_pkg::ADDR_W-1:0] mem_sel,
  output logic accepted,
  output nib_alu_pkg::wb_t wb,
  output logic skip_next,
  output logic carry_flag
);
  import nib_alu_pkg::*;

  // Elaboration check: the datapath is built for one nibble width only
  if (NIB != NIB_W) begin : g_nib_check
    $error("NIB must equal the nibble width");
  end

  dec_t dec;
  logic [NIB_W-1:0] opnd_a;
  logic [NIB_W-1:0] opnd_b;
  logic cin_bit;
  logic [NIB_W:0] add_res;
  logic [NIB_W:0] sub_res;
  logic [NIB_W-1:0] result;
  logic cout;
  logic execute;
  logic skip_pending;

  // Field decode at fixed positions
  always_comb begin
    dec.arith = (instr[GRP_HI:GRP_LO] == GRP_ARITH);
    dec.sub = instr[SUB_BIT];
    dec.imm = instr[IMM_BIT];
    dec.cin = instr[CIN_BIT];
    dec.skip = instr[SKIP_BIT];
    dec.row_field = instr[ROW_HI:ROW_LO];
    dec.column_field = instr[COL_HI:COL_LO];
    dec.operand = instr[OPD_HI:OPD_LO];
  end

  // Operand addresses to the register file and data memory
  assign reg_sel = dec.operand;
  assign mem_sel = {dec.row_field, dec.column_field};
  assign accepted = instr_valid && dec.arith;

  // Instruction fetched after a taken skip is dropped
  assign execute = accepted && !skip_pending;

  // Register forms: a = register, b = memory. Immediate: a = memory, b = imm
  always_comb begin
    if (dec.imm) begin
      opnd_a = mem_data;
      opnd_b = dec.operand;
    end else begin
      opnd_a = reg_data;
      opnd_b = mem_data;
    end
    cin_bit = dec.cin & carry_flag;
    add_res = {1'b0, opnd_a} + {1'b0, opnd_b} + {{NIB_W{1'b0}}, cin_bit};
    sub_res = {1'b0, opnd_a} - {1'b0, opnd_b} - {{NIB_W{1'b0}}, cin_bit};
    result = dec.sub ? sub_res[NIB_W-1:0] : add_res[NIB_W-1:0];
    cout = dec.sub ? sub_res[NIB_W] : add_res[NIB_W]; // borrow or carry
  end

  // Skip state: set by a skip variant with carry or borrow
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      skip_pending <= 1'b0;
    end else if (instr_valid) begin
      skip_pending <= execute && dec.skip && cout;
    end
  end
  assign skip_next = skip_pending;

  // Carry/borrow flag update
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      carry_flag <= FLAG_RESET;
    end else if (execute) begin
      carry_flag <= cout;
    end
  end

  // Write-back: register forms to register, immediate forms to memory
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wb <= '0;
    end else begin
      wb.reg_we <= execute && !dec.imm;
      wb.mem_we <= execute && dec.imm;
      wb.work_reg_num <= dec.operand;
      wb.mem_addr <= {dec.row_field, dec.column_field};
      wb.data <= result;
    end
  end

  // Assertions
  sequence s_skip_cause;
    execute && dec.skip && cout;
  endsequence

  // Word dropped because the previous one asked for a skip
  sequence s_skipped_word;
    accepted && skip_pending;
  endsequence

  // Executed register form
  sequence s_reg_op;
    execute && !dec.imm;
  endsequence

  // Executed immediate form
  sequence s_imm_op;
    execute && dec.imm;
  endsequence

  AST_SKIP_ON_COUT: assert property (@(posedge clock) disable iff (!arst_n)
    s_skip_cause |=> skip_next)
    else $error("skip not raised after carry or borrow");

  AST_NO_SKIP_PLAIN: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.skip) |=> !skip_next)
    else $error("skip raised by non-skip variant");

  AST_SKIPPED_NO_WB: assert property (@(posedge clock) disable iff (!arst_n)
    (accepted && skip_pending) |=> !wb.reg_we && !wb.mem_we)
    else $error("skipped instruction wrote back");

  AST_SKIPPED_FLAG: assert property (@(posedge clock) disable iff (!arst_n)
    (accepted && skip_pending) |=> $stable(carry_flag))
    else $error("skipped instruction changed flag");

  AST_REG_ADD: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.imm && !dec.sub) |=>
      wb.reg_we && wb.data == 4'($past(reg_data) + $past(mem_data)
        + 4'($past(cin_bit))))
    else $error("register add result wrong");

  AST_IMM_SUB: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && dec.sub) |=>
      wb.mem_we && wb.data == 4'($past(mem_data) - $past(dec.operand)
        - 4'($past(cin_bit))))
    else $error("memory subtract result wrong");

  AST_MEM_ADDR: assert property (@(posedge clock) disable iff (!arst_n)
    execute |=> wb.mem_addr == {$past(instr[ROW_HI:ROW_LO]),
      $past(instr[COL_HI:COL_LO])})
    else $error("memory address fields wrong");

  AST_FLAG_UPDATE: assert property (@(posedge clock) disable iff (!arst_n)
    execute |=> carry_flag == $past(cout))
    else $error("carry flag not updated");

  AST_NONARITH_IDLE: assert property (@(posedge clock) disable iff (!arst_n)
    (instr_valid && instr[GRP_HI:GRP_LO] != GRP_ARITH) |=>
      !wb.reg_we && !wb.mem_we)
    else $error("non-arithmetic word executed");

  // Per-opcode results, expected values from the operand ports
  AST_PLAIN_ADD_REG: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.imm && !dec.sub && !dec.cin) |=>
      wb.reg_we && wb.data == 4'($past(reg_data) + $past(mem_data)))
    else $error("plain register add result wrong");

  AST_ADD_CIN_SKIP: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.imm && !dec.sub && dec.cin && dec.skip && cout)
      |=> skip_next && wb.reg_we)
    else $error("carry-in add skip missing");

  AST_IMM_ADD: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && !dec.sub && !dec.cin) |=>
      wb.mem_we && wb.data == 4'($past(mem_data) + $past(dec.operand)))
    else $error("immediate add result wrong");

  AST_IMM_ADD_CIN: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && !dec.sub && dec.cin) |=>
      wb.mem_we && wb.data == 4'($past(mem_data) + $past(dec.operand)
        + 4'($past(carry_flag))))
    else $error("immediate add with carry result wrong");

  AST_REG_SUB: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.imm && dec.sub && !dec.cin) |=>
      wb.reg_we && wb.data == 4'($past(reg_data) - $past(mem_data)))
    else $error("register subtract result wrong");

  AST_REG_SUB_SKIP: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.imm && dec.sub && dec.skip && cout)
      |=> skip_next && wb.reg_we)
    else $error("register subtract skip missing");

  AST_REG_SUB_BIN: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && !dec.imm && dec.sub && dec.cin) |=>
      wb.reg_we && wb.data == 4'($past(reg_data) - $past(mem_data)
        - 4'($past(carry_flag))))
    else $error("register subtract with borrow result wrong");

  AST_IMM_SUB_SKIP: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && dec.sub && !dec.cin && dec.skip && cout)
      |=> skip_next && wb.mem_we)
    else $error("immediate subtract skip missing");

  AST_IMM_SUB_BIN: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && dec.sub && dec.cin) |=>
      wb.mem_we && wb.data == 4'($past(mem_data) - $past(dec.operand)
        - 4'($past(carry_flag))))
    else $error("immediate subtract with borrow result wrong");

  AST_IMM_BIN_SKIP: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && dec.sub && dec.cin && dec.skip && cout)
      |=> skip_next && wb.mem_we)
    else $error("immediate borrow skip missing");

  AST_ADD_SKIP_IMM: assert property (@(posedge clock) disable iff (!arst_n)
    (execute && dec.imm && !dec.sub && dec.skip && cout)
      |=> skip_next)
    else $error("immediate add skip missing");

  // Operand addressing toward register file and memory
  AST_REG_SEL: assert property (@(posedge clock) disable iff (!arst_n)
    accepted |-> reg_sel == instr[OPD_HI:OPD_LO])
    else $error("register select wrong");

  AST_MEM_SEL: assert property (@(posedge clock) disable iff (!arst_n)
    accepted |->
      mem_sel == {instr[ROW_HI:ROW_LO], instr[COL_HI:COL_LO]})
    else $error("memory select wrong");

  AST_REG_NUM: assert property (@(posedge clock) disable iff (!arst_n)
    s_reg_op |=> wb.work_reg_num == $past(instr[OPD_HI:OPD_LO]))
    else $error("write-back register number wrong");

  // Destination of each form
  AST_REG_FORM_DEST: assert property (@(posedge clock) disable iff (!arst_n)
    s_reg_op |=> wb.reg_we && !wb.mem_we)
    else $error("register form wrote memory");

  AST_IMM_FORM_DEST: assert property (@(posedge clock) disable iff (!arst_n)
    s_imm_op |=> wb.mem_we && !wb.reg_we)
    else $error("immediate form wrote register");

  AST_ACCEPT_GROUP: assert property (@(posedge clock) disable iff (!arst_n)
    accepted |-> instr[GRP_HI:GRP_LO] == GRP_ARITH)
    else $error("word of another group accepted");

  // Skip and flag bookkeeping between words
  AST_SKIP_CLEARS: assert property (@(posedge clock) disable iff (!arst_n)
    s_skipped_word |=> !skip_next)
    else $error("skip not cleared by dropped word");

  AST_IDLE_NO_WB: assert property (@(posedge clock) disable iff (!arst_n)
    !instr_valid |=> !wb.reg_we && !wb.mem_we)
    else $error("write-back without a word");

  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    !execute |=> $stable(carry_flag))
    else $error("flag changed without an executed word");

  AST_SKIP_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    !instr_valid |=> $stable(skip_next))
    else $error("skip changed without a word");

  AST_SKIP_SOURCE: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(skip_next) |-> $past(execute) && $past(dec.skip))
    else $error("skip raised by a non-skip word");
endmodule : nibble_add_sub_skip_unit

// [verif/nibble_add_sub_skip_unit_tb_top.sv]
// Self-checking bench for the nibble add/subtract/skip unit.
// Assumes one 250 MHz clock; the bench plays core, registers and memory.
`timescale 1ns/1ps
module nibble_add_sub_skip_unit_tb_top;
  import nib_alu_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  logic [WORD_W-1:0] instr = 16'h0000;
  logic [NIB_W-1:0] reg_data = 4'h0;
  logic [NIB_W-1:0] mem_data = 4'h0;
  logic [NIB_W-1:0] reg_sel;
  logic [ADDR_W-1:0] mem_sel;
  logic accepted, skip_next, carry_flag;
  wb_t wb;
  logic cy = 1'b0;
  logic skp = 1'b0;
  int fail_count = 0;
  int n_compared = 0;
  // Clock of 4 ns
  always #2 clock = ~clock;
  nibble_add_sub_skip_unit DUT (.clock(clock), .arst_n(arst_n),
    .instr_valid(instr_valid), .instr(instr), .reg_data(reg_data),
    .mem_data(mem_data), .reg_sel(reg_sel), .mem_sel(mem_sel),
    .accepted(accepted), .wb(wb), .skip_next(skip_next),
    .carry_flag(carry_flag));
  // Compare of one flag
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk_bit
  // Compare of write-back; payload only matters with a write enable
  task automatic chk_wb(input wb_t e);
    n_compared++;
    if (wb.reg_we !== e.reg_we || wb.mem_we !== e.mem_we ||
        (e.reg_we && wb.work_reg_num !== e.work_reg_num) ||
        (e.mem_we && wb.mem_addr !== e.mem_addr) ||
        ((e.reg_we || e.mem_we) && wb.data !== e.data)) begin
      fail_count++;
      $display("wrong value at %0t: write-back %h not %h", $time, wb, e);
    end
  endtask : chk_wb
  // One word with operands; expectation kept in a flag and skip model
  task automatic issue(input logic [15:0] w, input logic [3:0] r, m);
    logic [4:0] res;
    logic ex;
    wb_t e;
    e = '0;
    ex = !skp && w[15:14] == GRP_ARITH;
    res = w[12] ? {1'b0, m} : {1'b0, r};
    if (w[13]) res = res - (w[12] ? w[3:0] : m) - (w[11] & cy);
    else res = res + (w[12] ? w[3:0] : m) + (w[11] & cy);
    e.reg_we = ex & ~w[12];
    e.mem_we = ex & w[12];
    e.work_reg_num = w[3:0];
    e.mem_addr = w[9:4];
    e.data = res[3:0];
    @(posedge clock);
    instr_valid <= 1'b1;
    instr <= w;
    reg_data <= r;
    mem_data <= m;
    #1;
    chk_bit(mem_sel === w[9:4] && reg_sel === w[3:0], 1'b1);
    chk_bit(accepted, w[15:14] == 2'h1);
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    if (ex) cy = res[4];
    skp = ex & w[10] & res[4];
    chk_wb(e);
    chk_bit(carry_flag, cy);
    chk_bit(skip_next, skp);
  endtask : issue
  // Every opcode: carry or borrow word, then two plain words
  task automatic t_codes();
    for (int op = 0; op < 16; op++) begin
      issue({2'h1, 4'(op), 10'h3F1}, op[3] ? 4'h0 : 4'hF,
        op[3] & op[2] ? 4'h0 : 4'hF);
      issue({2'h1, 4'(op), 10'h1A2}, 4'h5, 4'h3);
      issue({2'h1, 4'(op), 10'h1A2}, 4'h5, 4'h3);
    end
  endtask : t_codes
  // Corner rows and columns of the memory operand
  task automatic t_fields();
    for (int k = 0; k < 4; k++) begin
      issue({6'h14, 2'(k), k[0] ? 4'hF : 4'h0, 4'h7}, 4'h1, 4'h8);
    end
  endtask : t_fields
  // Other groups do nothing, even after a pending skip
  task automatic t_refuse();
    issue(16'h47FF, 4'hF, 4'hF);
    issue(16'h8123, 4'h1, 4'h1);
    issue(16'h0000, 4'h1, 4'h1);
  endtask : t_refuse
  // Final counts and verdict
  task automatic tally_and_finish();
    $display("compared %0d, wrong %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  // Guard against a hung run
  initial begin
    #100000;
    fail_count++;
    tally_and_finish();
  end
  // Reset, then the scenarios
  initial begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    t_codes();
    t_fields();
    t_refuse();
    tally_and_finish();
  end
endmodule : nibble_add_sub_skip_unit_tb_top
